// >>> logic/data_mem_pkg.sv
// Constants and carrier types for the internal data memory and special-register decode
package data_mem_pkg;
  // Memory geometry
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] RAM_TOP = 8'hff;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam int RECORD_BITS = 32;
  localparam logic [5:0] RECORD_FULL = 6'h20;
  // Special-register addresses held inside this block
  localparam logic [7:0] SFR_STACK_TOP = 8'h81;
  localparam logic [7:0] SFR_DPTR_LOW = 8'h82;
  localparam logic [7:0] SFR_DPTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_STATUS = 8'hd0;
  localparam logic [7:0] SFR_ACCUM = 8'he0;
  localparam logic [7:0] SFR_MULDIV = 8'hf0;
  // Reset values
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Status word field positions
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_PARITY = 0;

  // How the operand address is formed
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_REG
  } addr_mode_t;

  // Stack operations from the sequencer
  typedef enum logic [2:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP,
    STK_INC,
    STK_DEC,
    STK_CALL,
    STK_RET
  } stk_op_t;

  // One operand access; addr is a register number, index select, byte or bit address
  typedef struct packed {
    logic valid;
    logic write;
    logic is_bit;
    addr_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wbit;
  } mem_req_t;

  // Access forwarded to peripheral special registers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage : data_mem_pkg

// >>> logic/data_mem_map.sv
// Internal data RAM, register banks, bit area, stack, stack record and core special registers
`timescale 1ns/10ps
module data_mem_map
  import data_mem_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Operand access from the sequencer
  input wire mem_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rbit_o,
  output logic rvalid_o,
  // Stack operations
  input wire stk_op_t stk_op_i,
  input wire logic [15:0] stk_wdata_i,
  output logic [15:0] stk_rdata_o,
  // Peripheral special registers outside this block
  output sfr_req_t ext_req_o,
  input wire logic [7:0] ext_rdata_i,
  // Core state views
  output logic [7:0] stack_top_pointer_o,
  output logic [7:0] processor_status_word_o,
  output logic [7:0] accumulator_o,
  output logic [15:0] data_pointer_o,
  // Stack record to debug logic
  output logic [RECORD_BITS-1:0] rec_bits_o,
  output logic [5:0] rec_depth_o,
  output logic rec_overflow_o,
  output logic rec_underflow_o
);

  logic [7:0] ram_r [RAM_BYTES];
  logic [7:0] stack_top_pointer_r;
  logic [7:0] data_pointer_low_r;
  logic [7:0] data_pointer_high_r;
  logic [7:0] psw_r;
  logic [7:0] accumulator_r;
  logic [7:0] muldiv_r;
  logic [RECORD_BITS-1:0] rec_r;
  logic [5:0] depth_r;
  logic [1:0] bank_sel;
  logic [7:0] psw_view;
  logic tgt_sfr;
  logic [7:0] tgt_addr;
  logic [2:0] tgt_bit;
  logic [7:0] cur_byte;
  logic [7:0] merged_byte;
  logic local_sfr;
  logic do_write;
  logic [7:0] sp_plus1;
  logic [7:0] sp_plus2;
  logic [7:0] sp_minus1;

  // Even parity flag over the accumulator
  function automatic logic odd_parity(input logic [7:0] v);
    return ^v;
  endfunction : odd_parity

  // Byte address of a bank register for the active bank
  function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank, input logic [2:0] num);
    return {3'b000, bank, num};
  endfunction : bank_reg_addr

  // Parity is computed live, so software writes to that bit have no effect
  assign bank_sel = {psw_r[PSW_BANK_HI], psw_r[PSW_BANK_LO]};
  assign psw_view = {psw_r[7:1], odd_parity(accumulator_r)};
  assign sp_plus1 = 8'(stack_top_pointer_r + 8'h01);
  assign sp_plus2 = 8'(stack_top_pointer_r + 8'h02);
  assign sp_minus1 = 8'(stack_top_pointer_r - 8'h01);

  // Resolve the operand to RAM or special-register space
  always_comb begin
    tgt_sfr = 1'b0;
    tgt_addr = req_i.addr;
    tgt_bit = 3'h0;
    if (req_i.is_bit) begin
      tgt_bit = req_i.addr[2:0];
      if (req_i.addr[7]) begin
        tgt_sfr = 1'b1;
        tgt_addr = {req_i.addr[7:3], 3'b000};
      end else begin
        tgt_addr = 8'(BIT_AREA_BASE + {4'h0, req_i.addr[6:3]});
      end
    end else begin
      case (req_i.mode)
        MODE_REG: tgt_addr = bank_reg_addr(bank_sel, req_i.addr[2:0]);
        // Indirect never reaches special registers, even above 0x7F
        MODE_INDIRECT: tgt_addr = ram_r[bank_reg_addr(bank_sel, {2'b00, req_i.addr[0]})];
        MODE_DIRECT: tgt_sfr = req_i.addr[7];
        default: tgt_addr = req_i.addr;
      endcase
    end
  end

  // Local special-register decode and current byte value
  always_comb begin
    local_sfr = 1'b1;
    cur_byte = BYTE_RESET;
    if (!tgt_sfr) begin
      local_sfr = 1'b0;
      cur_byte = ram_r[tgt_addr];
    end else begin
      case (tgt_addr)
        SFR_STACK_TOP: cur_byte = stack_top_pointer_r;
        SFR_DPTR_LOW: cur_byte = data_pointer_low_r;
        SFR_DPTR_HIGH: cur_byte = data_pointer_high_r;
        SFR_STATUS: cur_byte = psw_view;
        SFR_ACCUM: cur_byte = accumulator_r;
        SFR_MULDIV: cur_byte = muldiv_r;
        default: begin
          local_sfr = 1'b0;
          cur_byte = ext_rdata_i;
        end
      endcase
    end
    merged_byte = req_i.wdata;
    if (req_i.is_bit) begin
      merged_byte = cur_byte;
      merged_byte[tgt_bit] = req_i.wbit;
    end
  end

  assign do_write = req_i.valid && req_i.write;

  // Peripheral registers get a whole byte even for bit writes, so they never see partial data
  // Unoccupied addresses are forwarded as well; their answer is whatever the far side returns
  always_comb begin
    ext_req_o.valid = req_i.valid && tgt_sfr && !local_sfr;
    ext_req_o.write = req_i.write;
    ext_req_o.addr = tgt_addr;
    ext_req_o.wdata = merged_byte;
  end

  // RAM array: operand writes, then stack writes which take precedence on a clash
  always_ff @(posedge sys_clk_i) begin
    if (do_write && !tgt_sfr) begin
      ram_r[tgt_addr] <= merged_byte;
    end
    case (stk_op_i)
      STK_PUSH: ram_r[sp_plus1] <= stk_wdata_i[7:0];
      STK_CALL: begin
        ram_r[sp_plus1] <= stk_wdata_i[7:0];
        ram_r[sp_plus2] <= stk_wdata_i[15:8];
      end
      default: ;
    endcase
  end

  // Stack pointer; a stack operation wins over a direct write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stack_top_pointer_r <= SP_RESET;
    end else begin
      case (stk_op_i)
        STK_PUSH, STK_INC: stack_top_pointer_r <= sp_plus1;
        STK_CALL: stack_top_pointer_r <= sp_plus2;
        STK_POP, STK_DEC: stack_top_pointer_r <= sp_minus1;
        STK_RET: stack_top_pointer_r <= 8'(stack_top_pointer_r - 8'h02);
        default: begin
          if (do_write && tgt_sfr && tgt_addr == SFR_STACK_TOP) begin
            stack_top_pointer_r <= merged_byte;
          end
        end
      endcase
    end
  end

  // Other core special registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_pointer_low_r <= BYTE_RESET;
      data_pointer_high_r <= BYTE_RESET;
      psw_r <= BYTE_RESET;
      accumulator_r <= BYTE_RESET;
      muldiv_r <= BYTE_RESET;
    end else if (do_write && tgt_sfr) begin
      case (tgt_addr)
        SFR_DPTR_LOW: data_pointer_low_r <= merged_byte;
        SFR_DPTR_HIGH: data_pointer_high_r <= merged_byte;
        SFR_STATUS: psw_r <= merged_byte;
        SFR_ACCUM: accumulator_r <= merged_byte;
        SFR_MULDIV: muldiv_r <= merged_byte;
        default: ;
      endcase
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= BYTE_RESET;
      rbit_o <= 1'b0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.valid && !req_i.write;
      if (req_i.valid && !req_i.write) begin
        rdata_o <= cur_byte;
        rbit_o <= cur_byte[tgt_bit];
      end
    end
  end

  // Stack read answer; return pops high byte first since call pushed it last
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stk_rdata_o <= 16'h0000;
    end else begin
      case (stk_op_i)
        STK_POP: stk_rdata_o <= {8'h00, ram_r[stack_top_pointer_r]};
        STK_RET: stk_rdata_o <= {ram_r[stack_top_pointer_r], ram_r[sp_minus1]};
        default: ;
      endcase
    end
  end

  // Stack record: ones mark call bits, zeros mark push bits
  // Depth saturates so a runaway program cannot wrap the counter and hide the fault
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rec_r <= '0;
      depth_r <= 6'h00;
      rec_overflow_o <= 1'b0;
      rec_underflow_o <= 1'b0;
    end else begin
      rec_overflow_o <= 1'b0;
      rec_underflow_o <= 1'b0;
      case (stk_op_i)
        STK_PUSH, STK_INC: begin
          rec_r <= {rec_r[RECORD_BITS-2:0], 1'b0};
          if (depth_r == RECORD_FULL) rec_overflow_o <= 1'b1;
          else depth_r <= 6'(depth_r + 6'h01);
        end
        STK_CALL: begin
          rec_r <= {rec_r[RECORD_BITS-3:0], 2'b11};
          if (depth_r > 6'(RECORD_FULL - 6'h02)) begin
            rec_overflow_o <= 1'b1;
            depth_r <= RECORD_FULL;
          end else begin
            depth_r <= 6'(depth_r + 6'h02);
          end
        end
        STK_POP, STK_DEC: begin
          rec_r <= {1'b0, rec_r[RECORD_BITS-1:1]};
          if (depth_r == 6'h00) rec_underflow_o <= 1'b1;
          else depth_r <= 6'(depth_r - 6'h01);
        end
        STK_RET: begin
          rec_r <= {2'b00, rec_r[RECORD_BITS-1:2]};
          if (depth_r < 6'h02) begin
            rec_underflow_o <= 1'b1;
            depth_r <= 6'h00;
          end else begin
            depth_r <= 6'(depth_r - 6'h02);
          end
        end
        default: ;
      endcase
    end
  end

  // State views
  assign stack_top_pointer_o = stack_top_pointer_r;
  assign processor_status_word_o = psw_view;
  assign accumulator_o = accumulator_r;
  assign data_pointer_o = {data_pointer_high_r, data_pointer_low_r};
  assign rec_bits_o = rec_r;
  assign rec_depth_o = depth_r;

  // Helpers seen only by the checks below
  logic [7:0] top_byte;
  logic [7:0] bank_r0_byte;
  logic [7:0] ram_at_req;
  assign top_byte = ram_r[stack_top_pointer_r];
  assign bank_r0_byte = ram_r[bank_reg_addr(bank_sel, 3'h0)];
  assign ram_at_req = ram_r[req_i.addr];

  a_sp_reset_val:
  assert property (@(posedge sys_clk_i) rst_i |=> stack_top_pointer_r == SP_RESET && depth_r == 6'h00)
    else $error("stack pointer not 0x07 after reset");

  a_push_pointer:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stk_op_i == STK_PUSH |=> stack_top_pointer_r == 8'($past(stack_top_pointer_r) + 8'h01)
      && top_byte == $past(stk_wdata_i[7:0]))
    else $error("push did not store at pointer plus one");

  a_pop_pointer:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stk_op_i == STK_POP |=> stk_rdata_o[7:0] == $past(top_byte)
      && stack_top_pointer_r == 8'($past(stack_top_pointer_r) - 8'h01))
    else $error("pop returned wrong byte or pointer");

  a_reg_bank_write:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.valid && req_i.write && !req_i.is_bit && req_i.mode == MODE_REG && req_i.addr[2:0] == 3'h0
      && stk_op_i == STK_NONE |=> bank_r0_byte == $past(req_i.wdata))
    else $error("register write missed the active bank");

  a_direct_upper_sep:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.valid && req_i.write && !req_i.is_bit && req_i.mode == MODE_DIRECT && req_i.addr[7]
      && stk_op_i == STK_NONE |=> $stable(ram_at_req))
    else $error("direct upper write changed RAM");

  a_direct_upper_ext:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.valid && !req_i.is_bit && req_i.mode == MODE_DIRECT && req_i.addr >= UPPER_BASE
      && !local_sfr |-> ext_req_o.valid && ext_req_o.addr == req_i.addr)
    else $error("direct upper access not forwarded");

  a_indirect_never_sfr:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.valid && !req_i.is_bit && req_i.mode == MODE_INDIRECT |-> !ext_req_o.valid)
    else $error("indirect access reached special registers");

  a_record_overflow:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stk_op_i == STK_PUSH && depth_r == RECORD_FULL |=> rec_overflow_o ##1 !rec_overflow_o || stk_op_i != STK_NONE)
    else $error("record overflow not flagged");

  a_record_underflow:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stk_op_i == STK_RET && depth_r < 6'h02 |=> rec_underflow_o && depth_r == 6'h00)
    else $error("record underflow not flagged");

  a_call_depth:
  assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stk_op_i == STK_CALL && depth_r < 6'h1f |=> depth_r == 6'($past(depth_r) + 6'h02) && rec_r[1:0] == 2'b11)
    else $error("call did not push two record bits");

endmodule : data_mem_map

// >>> verification/sfr_periph_model.sv
// Peripheral special-register model that answers accesses forwarded by the memory map
`timescale 1ns/10ps
module sfr_periph_model
  import data_mem_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Forwarded access
  input wire sfr_req_t req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] regs_r [256];
  logic [7:0] idle_r = 8'h5a;

  // Known start pattern, so a read before any write can still be checked
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs_r[i] = 8'(i) ^ 8'ha5;
    end
  end

  // Store writes; the idle pattern flips every cycle so a stale byte never passes
  always @(posedge sys_clk_i) begin
    idle_r <= ~idle_r;
    if (req_i.valid && req_i.write) begin
      regs_r[req_i.addr] <= req_i.wdata;
    end
  end

  // Same-cycle answer, only while a register is selected; every one of the 256 addresses answers from the array
  assign rdata_o = req_i.valid ? regs_r[req_i.addr] : idle_r;
endmodule : sfr_periph_model

// >>> verification/testbench.sv
// Self-checking testbench for the internal data memory map
`timescale 1ns/10ps
module testbench
  import data_mem_pkg::*;
;
  logic sys_clk_i;
  logic rst_i;
  mem_req_t req_i;
  stk_op_t stk_op_i;
  logic [15:0] stk_wdata_i;
  logic [7:0] rdata_o;
  logic rbit_o;
  logic rvalid_o;
  logic [15:0] stk_rdata_o;
  sfr_req_t ext_req_o;
  logic [7:0] ext_rdata_i;
  logic [7:0] stack_top_pointer_o;
  logic [7:0] processor_status_word_o;
  logic [7:0] accumulator_o;
  logic [15:0] data_pointer_o;
  logic [RECORD_BITS-1:0] rec_bits_o;
  logic [5:0] rec_depth_o;
  logic rec_overflow_o;
  logic rec_underflow_o;
  int fail_count = 0;
  int check_count = 0;

  data_mem_map u_data_mem_map (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .rbit_o(rbit_o), .rvalid_o(rvalid_o), .stk_op_i(stk_op_i), .stk_wdata_i(stk_wdata_i),
    .stk_rdata_o(stk_rdata_o), .ext_req_o(ext_req_o), .ext_rdata_i(ext_rdata_i),
    .stack_top_pointer_o(stack_top_pointer_o), .processor_status_word_o(processor_status_word_o),
    .accumulator_o(accumulator_o), .data_pointer_o(data_pointer_o), .rec_bits_o(rec_bits_o),
    .rec_depth_o(rec_depth_o), .rec_overflow_o(rec_overflow_o), .rec_underflow_o(rec_underflow_o));

  sfr_periph_model u_sfr_periph_model (.sys_clk_i(sys_clk_i), .req_i(ext_req_o), .rdata_o(ext_rdata_i));

  // Clock at 100 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Counts a comparison and reports a mismatch at once
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One operand access held for exactly one taken edge; wbit rides in d[0]
  task automatic access(input logic w, input logic b, input addr_mode_t m, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    req_i = '{valid: 1'b1, write: w, is_bit: b, mode: m, addr: a, wdata: d, wbit: d[0]};
    @(posedge sys_clk_i);
    #1;
    req_i.valid = 1'b0;
  endtask : access

  // Read and compare; the valid pulse must already be up 1 ns after the taken edge
  task automatic rd(input logic b, input addr_mode_t m, input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, b, m, a, 8'h00);
    check({7'h00, rvalid_o, b ? {7'h00, rbit_o} : rdata_o}, {8'h01, exp});
  endtask : rd

  // One stack operation
  task automatic stk(input stk_op_t op, input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    stk_op_i = op;
    stk_wdata_i = d;
    @(posedge sys_clk_i);
    #1;
    stk_op_i = STK_NONE;
  endtask : stk

  // Prints the counts and the verdict, then stops
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the 150 or so cycles the tests need
  initial begin
    #200000;
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    req_i = '0;
    stk_op_i = STK_NONE;
    stk_wdata_i = 16'h0000;
    repeat (5) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    check(16'(stack_top_pointer_o), 16'h0007);
    rd(1'b0, MODE_DIRECT, 8'h81, 8'h07);
    check({2'b00, rec_depth_o, processor_status_word_o}, 16'h0000);
    // Each bank code steers register 5 to its own byte
    for (int b = 0; b < 4; b++) begin
      access(1'b1, 1'b0, MODE_DIRECT, SFR_STATUS, 8'(b << 3));
      check(16'(processor_status_word_o), 16'(b << 3));
      access(1'b1, 1'b0, MODE_REG, 8'h05, 8'(8'h40 + b));
      rd(1'b0, MODE_DIRECT, 8'(b * 8 + 5), 8'(8'h40 + b));
    end
    rd(1'b0, MODE_REG, 8'h05, 8'h43);
    // Indirect through bank 0 index registers, upper RAM against the peripheral space
    access(1'b1, 1'b0, MODE_DIRECT, SFR_STATUS, 8'h00);
    access(1'b1, 1'b0, MODE_REG, 8'h00, 8'h90);
    access(1'b1, 1'b0, MODE_REG, 8'h01, 8'h30);
    access(1'b1, 1'b0, MODE_INDIRECT, 8'h00, 8'h3c);
    access(1'b1, 1'b0, MODE_DIRECT, 8'h90, 8'hc3);
    rd(1'b0, MODE_INDIRECT, 8'h00, 8'h3c);
    rd(1'b0, MODE_DIRECT, 8'h90, 8'hc3);
    access(1'b1, 1'b0, MODE_INDIRECT, 8'h01, 8'h77);
    rd(1'b0, MODE_DIRECT, 8'h30, 8'h77);
    access(1'b1, 1'b0, MODE_INDIRECT, 8'h00, 8'hff);
    rd(1'b0, MODE_DIRECT, 8'h90, 8'hc3);
    // Bit area: bit 0x13 is bit 3 of 0x22, bit 0x7f is bit 7 of 0x2f
    access(1'b1, 1'b0, MODE_DIRECT, 8'h22, 8'h00);
    access(1'b1, 1'b1, MODE_DIRECT, 8'h13, 8'h01);
    rd(1'b0, MODE_DIRECT, 8'h22, 8'h08);
    rd(1'b1, MODE_DIRECT, 8'h13, 8'h01);
    access(1'b1, 1'b0, MODE_DIRECT, 8'h2f, 8'h00);
    access(1'b1, 1'b1, MODE_DIRECT, 8'h7f, 8'h01);
    rd(1'b0, MODE_DIRECT, 8'h2f, 8'h80);
    // Accumulator, multiply/divide register and pointer bytes
    access(1'b1, 1'b0, MODE_DIRECT, SFR_ACCUM, 8'h55);
    check({accumulator_o, 7'h00, processor_status_word_o[0]}, 16'h5500);
    access(1'b1, 1'b1, MODE_DIRECT, 8'he0, 8'h00);
    check({accumulator_o, 7'h00, processor_status_word_o[0]}, 16'h5401);
    access(1'b1, 1'b0, MODE_DIRECT, SFR_MULDIV, 8'h9a);
    rd(1'b0, MODE_DIRECT, SFR_MULDIV, 8'h9a);
    rd(1'b1, MODE_DIRECT, 8'hf3, 8'h01);
    access(1'b1, 1'b0, MODE_DIRECT, SFR_DPTR_LOW, 8'h34);
    access(1'b1, 1'b0, MODE_DIRECT, SFR_DPTR_HIGH, 8'h12);
    check(data_pointer_o, 16'h1234);
    rd(1'b0, MODE_DIRECT, SFR_DPTR_LOW, 8'h34);
    // Stack: push, pop, call, return, increment, decrement
    stk(STK_PUSH, 16'h00aa);
    check({stack_top_pointer_o, 2'b00, rec_depth_o}, 16'h0801);
    rd(1'b0, MODE_DIRECT, 8'h08, 8'haa);
    stk(STK_POP, 16'h0000);
    check(stk_rdata_o, 16'h00aa);
    check({stack_top_pointer_o, 2'b00, rec_depth_o}, 16'h0700);
    stk(STK_CALL, 16'h1234);
    check({stack_top_pointer_o, 2'b00, rec_depth_o}, 16'h0902);
    rd(1'b0, MODE_DIRECT, 8'h08, 8'h34);
    rd(1'b0, MODE_DIRECT, 8'h09, 8'h12);
    stk(STK_RET, 16'h0000);
    check(stk_rdata_o, 16'h1234);
    stk(STK_INC, 16'h0000);
    check({stack_top_pointer_o, 2'b00, rec_depth_o}, 16'h0801);
    stk(STK_DEC, 16'h0000);
    check({stack_top_pointer_o, 2'b00, rec_depth_o}, 16'h0700);
    // Empty record underflows on a return
    stk(STK_RET, 16'h0000);
    check({9'h000, rec_underflow_o, rec_depth_o}, 16'h0040);
    // Move the stack high, then fill the record past 32 bits
    access(1'b1, 1'b0, MODE_DIRECT, SFR_STACK_TOP, 8'h40);
    rd(1'b0, MODE_DIRECT, SFR_STACK_TOP, 8'h40);
    for (int i = 0; i < 16; i++) begin
      stk(STK_CALL, 16'(i));
    end
    check({9'h000, rec_overflow_o, rec_depth_o}, 16'h0020);
    check(rec_bits_o[15:0], 16'hffff);
    stk(STK_CALL, 16'h0000);
    check({9'h000, rec_overflow_o, rec_depth_o}, 16'h0060);
    check(16'(stack_top_pointer_o), 16'h0062);
    // A push on a full record flags overflow again and shifts in a push bit
    stk(STK_PUSH, 16'h0011);
    check({9'h000, rec_overflow_o, rec_depth_o}, 16'h0060);
    check(rec_bits_o[15:0], 16'hfffe);
    results();
  end
endmodule : testbench
